// ---- src/irq_prio_reg.v ----
`timescale 1ns/100ps
`include "prio_map.vh"
// Priority register zero with AHB-Lite slave and per-source request gating.
module irq_prio_reg
(
	clk,
	rstn,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hreadyout,
	hresp,
	hrdata,
	timer1_flag,
	outcmp1_flag,
	incap1_flag,
	ext_line0_flag,
	timer1_req,
	outcmp1_req,
	incap1_req,
	ext_line0_req,
	timer1_prio_level,
	outcmp1_prio_level,
	incap1_prio_level,
	ext_irq0_prio_level
);
	input  wire        clk;
	input  wire        rstn;
	input  wire        hsel;
	input  wire [31:0] haddr;
	input  wire [1:0]  htrans;
	input  wire        hwrite;
	input  wire [2:0]  hsize;
	input  wire [31:0] hwdata;
	input  wire        hready;
	output reg         hreadyout;
	output reg         hresp;
	output reg  [31:0] hrdata;
	input  wire        timer1_flag;
	input  wire        outcmp1_flag;
	input  wire        incap1_flag;
	input  wire        ext_line0_flag;
	output wire        timer1_req;
	output wire        outcmp1_req;
	output wire        incap1_req;
	output wire        ext_line0_req;
	output wire [2:0]  timer1_prio_level;
	output wire [2:0]  outcmp1_prio_level;
	output wire [2:0]  incap1_prio_level;
	output wire [2:0]  ext_irq0_prio_level;

	// ----------------------------------------
	// Bus capture
	// ----------------------------------------
	reg  [`ADDR_MSB:0] wr_addr_r;
	reg                wr_pend_r;
	reg  [15:0]        prio_r;
	reg  [15:0]        prio_nxt;
	reg  [3:0]         enable_r;
	reg  [3:0]         enable_nxt;
	reg  [31:0]        rdata_nxt;
	wire               addr_phase;
	wire [3:0]         req_vec;

	// Size is not checked: only whole-word transfers are expected
	assign addr_phase = hsel & htrans[1] & hready;

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_addr_r <= 12'h000;
			wr_pend_r <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			// Zero wait states, always OKAY
			wr_pend_r <= addr_phase & hwrite;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_phase)
				wr_addr_r <= haddr[`ADDR_MSB:0];
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @*
	begin
		prio_nxt   = prio_r;
		enable_nxt = enable_r;
		if (wr_pend_r)
		begin
			case (wr_addr_r)
				`PRIO_OFS:   prio_nxt   = hwdata[15:0] & `PRIO_IMPL_MASK;
				`ENABLE_OFS: enable_nxt = hwdata[3:0];
				default:     prio_nxt   = prio_r;
			endcase
		end
	end

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prio_r   <= `PRIO_RESET;
			enable_r <= `ENABLE_RESET;
		end
		else
		begin
			prio_r   <= prio_nxt;
			enable_r <= enable_nxt;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Gap bits are zeroed again here so a stray flop bit can never be read back
	wire [15:0]        prio_view;

	assign prio_view = {1'b0, prio_nxt[`TMR1_LSB +: 3], 1'b0, prio_nxt[`OC1_LSB +: 3],
	                    1'b0, prio_nxt[`IC1_LSB +: 3], 1'b0, prio_nxt[`EXT0_LSB +: 3]};

	// Read from the next value so a read right after a write sees the new data
	always @*
	begin
		rdata_nxt = 32'h00000000;
		case (haddr[`ADDR_MSB:0])
			`PRIO_OFS:    rdata_nxt = {16'h0000, prio_view};
			`ENABLE_OFS:  rdata_nxt = {28'h0000000, enable_nxt};
			`PENDING_OFS: rdata_nxt = {28'h0000000, req_vec};
			default:      rdata_nxt = 32'h00000000;
		endcase
	end

	// Hrdata holds between reads, so a master that samples late still sees its data
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hrdata <= 32'h00000000;
		else if (addr_phase & ~hwrite)
			hrdata <= rdata_nxt;
	end

	// ----------------------------------------
	// Request gating
	// ----------------------------------------
	assign req_vec = {ext_line0_req, incap1_req, outcmp1_req, timer1_req};

	// Each gate sees only its own field, so the zero gaps cannot raise a level
	// Enable bit order matches the pending status word: timer, compare, capture, external
	wire [2:0]         tmr1_field;
	wire [2:0]         oc1_field;
	wire [2:0]         ic1_field;
	wire [2:0]         ext0_field;
	wire               tmr1_en;
	wire               oc1_en;
	wire               ic1_en;
	wire               ext0_en;

	assign tmr1_field = prio_r[`TMR1_LSB +: 3];
	assign oc1_field  = prio_r[`OC1_LSB +: 3];
	assign ic1_field  = prio_r[`IC1_LSB +: 3];
	assign ext0_field = prio_r[`EXT0_LSB +: 3];
	assign tmr1_en    = enable_r[0];
	assign oc1_en     = enable_r[1];
	assign ic1_en     = enable_r[2];
	assign ext0_en    = enable_r[3];

	prio_gate u_tmr1
	(
		.clk     (clk),
		.rstn    (rstn),
		.flag    (timer1_flag),
		.enable  (tmr1_en),
		.prio    (tmr1_field),
		.req_r   (timer1_req),
		.level_r (timer1_prio_level)
	);

	prio_gate u_oc1
	(
		.clk     (clk),
		.rstn    (rstn),
		.flag    (outcmp1_flag),
		.enable  (oc1_en),
		.prio    (oc1_field),
		.req_r   (outcmp1_req),
		.level_r (outcmp1_prio_level)
	);

	prio_gate u_ic1
	(
		.clk     (clk),
		.rstn    (rstn),
		.flag    (incap1_flag),
		.enable  (ic1_en),
		.prio    (ic1_field),
		.req_r   (incap1_req),
		.level_r (incap1_prio_level)
	);

	prio_gate u_ext0
	(
		.clk     (clk),
		.rstn    (rstn),
		.flag    (ext_line0_flag),
		.enable  (ext0_en),
		.prio    (ext0_field),
		.req_r   (ext_line0_req),
		.level_r (ext_irq0_prio_level)
	);
endmodule

// ---- src/prio_map.vh ----
`ifndef PRIO_MAP_VH
`define PRIO_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PRIO_OFS       12'h000
`define ENABLE_OFS     12'h004
`define PENDING_OFS    12'h008
`define ADDR_MSB       11

// ----------------------------------------
// Field positions of the priority register
// ----------------------------------------
`define TMR1_LSB       12
`define OC1_LSB        8
`define IC1_LSB        4
`define EXT0_LSB       0
`define PRIO_IMPL_MASK 16'h7777

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PRIO_RESET     16'h4444
`define FIELD_RESET    3'h4
`define ENABLE_RESET   4'h0

`endif

// ---- src/prio_gate.v ----
`timescale 1ns/100ps
// Gates one source's flag by its enable and priority field.
module prio_gate
(
	clk,
	rstn,
	flag,
	enable,
	prio,
	req_r,
	level_r
);
	input  wire       clk;
	input  wire       rstn;
	input  wire       flag;
	input  wire       enable;
	input  wire [2:0] prio;
	output reg        req_r;
	output reg  [2:0] level_r;

	wire req_nxt;

	// Zero priority blocks the source even when enabled and flagged
	assign req_nxt = flag & enable & (prio != 3'h0);

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			req_r   <= 1'b0;
			level_r <= 3'h0;
		end
		else
		begin
			req_r   <= req_nxt;
			level_r <= req_nxt ? prio : 3'h0;
		end
	end
endmodule

// ---- test/irq_prio_props.sv ----
`timescale 1ns/100ps
module irq_prio_props
(
	input wire        clk,
	input wire        rstn,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	input wire        timer1_flag,
	input wire        outcmp1_flag,
	input wire        incap1_flag,
	input wire        ext_line0_flag,
	input wire        timer1_req,
	input wire        outcmp1_req,
	input wire        incap1_req,
	input wire        ext_line0_req,
	input wire [2:0]  timer1_prio_level,
	input wire [2:0]  outcmp1_prio_level,
	input wire [2:0]  incap1_prio_level,
	input wire [2:0]  ext_irq0_prio_level
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_t1_flag_gate: assert property (!$past(timer1_flag) |-> !timer1_req)
		else $error("timer1 request without flag");
	a_oc1_flag_gate: assert property (!$past(outcmp1_flag) |-> !outcmp1_req)
		else $error("outcmp1 request without flag");
	a_ic1_flag_gate: assert property (!$past(incap1_flag) |-> !incap1_req)
		else $error("incap1 request without flag");
	a_ext0_flag_gate: assert property (!$past(ext_line0_flag) |-> !ext_line0_req)
		else $error("ext0 request without flag");
	a_t1_level_req: assert property (timer1_req == (timer1_prio_level != 3'h0))
		else $error("timer1 level and request disagree");
	a_oc1_level_req: assert property (outcmp1_req == (outcmp1_prio_level != 3'h0))
		else $error("outcmp1 level and request disagree");
	a_ic1_level_req: assert property (incap1_req == (incap1_prio_level != 3'h0))
		else $error("incap1 level and request disagree");
	a_ext0_level_req: assert property (ext_line0_req == (ext_irq0_prio_level != 3'h0))
		else $error("ext0 level and request disagree");
	a_bus_resp_okay: assert property (hreadyout && !hresp)
		else $error("bus response not ready and okay");
	a_gap_bits_zero: assert property (hrdata[31:15] == 17'h00000 && !hrdata[11] && !hrdata[7])
		else $error("unimplemented read bits not zero");
endmodule
bind irq_prio_reg irq_prio_props i_irq_prio_props (.*);

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
	reg         clk = 0;
	reg         rstn = 0;
	reg  [31:0] haddr = 0;
	reg  [31:0] hwdata = 0;
	reg  [1:0]  htrans = 0;
	reg         hwrite = 0;
	reg  [3:0]  flg = 0;
	reg  [31:0] q;
	wire        rdy;
	wire        resp;
	wire [31:0] rd;
	wire [3:0]  rq;
	wire [11:0] lv;
	integer     failures = 0;
	integer     n_checks = 0;
	integer     cyc = 0;
	integer     c;
	always #25 clk = ~clk;
	irq_prio_reg i_irq_prio_reg (.clk(clk), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hresp(resp),
		.hrdata(rd), .timer1_flag(flg[3]), .outcmp1_flag(flg[2]), .incap1_flag(flg[1]),
		.ext_line0_flag(flg[0]), .timer1_req(rq[3]), .outcmp1_req(rq[2]), .incap1_req(rq[1]),
		.ext_line0_req(rq[0]), .timer1_prio_level(lv[11:9]), .outcmp1_prio_level(lv[8:6]),
		.incap1_prio_level(lv[5:3]), .ext_irq0_prio_level(lv[2:0]));
	task end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		n_checks = n_checks + 1;
		if (s !== e)
		begin
			failures = failures + 1;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Waits on hready rather than assuming zero wait states
	task bus(input [11:0] a, input w, input [31:0] d);
		@(posedge clk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		q = rd;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			failures = failures + 1;
			end_of_test;
		end
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rstn <= 1;
		bus(12'h000, 0, 0);
		chk(q, 32'h4444);
		bus(12'h000, 1, 32'hFFFFFFFF);
		bus(12'h000, 0, 0);
		chk(q, 32'h7777);
		chk(resp, 0);
		$display("reset and reserved bits done");
		bus(12'h004, 1, 32'hF);
		flg <= 4'hF;
		for (c = 0; c < 8; c = c + 1)
		begin
			bus(12'h000, 1, {4{1'b1, c[2:0]}});
			bus(12'h000, 0, 0);
			chk(q, {4{1'b0, c[2:0]}});
			repeat (3) @(posedge clk);
			chk(lv, {4{c[2:0]}});
			chk(rq, (c == 0) ? 4'h0 : 4'hF);
		end
		$display("code sweep done");
		bus(12'h000, 1, 32'h1234);
		repeat (3) @(posedge clk);
		chk(lv, {3'h1, 3'h2, 3'h3, 3'h4});
		bus(12'h004, 1, 32'h5);
		repeat (3) @(posedge clk);
		chk(rq, 4'hA);
		bus(12'h004, 0, 0);
		chk(q, 32'h5);
		bus(12'h008, 0, 0);
		chk(q, 32'h5);
		bus(12'h010, 0, 0);
		chk(q, 0);
		$display("field position and enable done");
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		bus(12'h000, 0, 0);
		chk(q, 32'h4444);
		chk(rq, 4'h0);
		$display("mid-run reset done");
		end_of_test;
	end
endmodule
